// file: verilog/oled_pkg.sv
// Constants and carriers for the OLED RAM addressing and re-map block.
// Assumes a host on the same clock that delivers command and data bytes.
// What this block does
// - Column command sets window and loads column pointer.
// - Horizontal mode steps column, wraps, advances row.
// - Row command sets window and loads row pointer.
// - Row pointer at end row reloads start row.
// - Window end wraps both pointers to start.
// - Write RAM stores data until next command.
// - Read RAM returns data until next command.
// - Re-map bit zero clear selects horizontal order.
// - Re-map bit zero set selects vertical order.
// - Re-map bit one mirrors RAM columns.
// - Re-map bit two reverses colour order.
// - Re-map bit four reverses common scan.
// - Re-map bit five interleaves odd/even commons.
// - Re-map top bits select colour depth.
// - Depth codes: 256, 65k, 262k, pseudo 262k.
// - Start line register 0..127 selects first row.
// - Low select marks command, high marks parameters.
package oled_pkg;
  localparam logic [7:0] CMD_COLUMN    = 8'h15;
  localparam logic [7:0] CMD_ROW       = 8'h75;
  localparam logic [7:0] CMD_WRITE_RAM = 8'h5c;
  localparam logic [7:0] CMD_READ_RAM  = 8'h5d;
  localparam logic [7:0] CMD_REMAP     = 8'ha0;
  localparam logic [7:0] CMD_START     = 8'ha1;

  localparam int REMAP_VERTICAL = 0;
  localparam int REMAP_MIRROR   = 1;
  localparam int REMAP_SWAP     = 2;
  localparam int REMAP_SCANREV  = 4;
  localparam int REMAP_SPLIT    = 5;
  localparam int REMAP_DEPTH_LO = 6;

  localparam logic [7:0] REMAP_RESET = 8'h40;
  localparam logic [6:0] ADDR_MAX    = 7'h7f;
  localparam logic [6:0] START_RESET = 7'h00;
  localparam int         FIFO_DEPTH  = 16;

  typedef enum logic [1:0] {
    DEPTH_256    = 2'h0,
    DEPTH_65K    = 2'h1,
    DEPTH_262K   = 2'h2,
    DEPTH_P262K  = 2'h3
  } depth_e;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_PARAM = 2'h1,
    ST_WRITE = 2'h3,
    ST_READ  = 2'h2
  } mode_e;

  typedef struct packed {
    logic       isData;
    logic [7:0] value;
  } host_byte_s;

  typedef struct packed {
    logic [5:0] compA;
    logic [5:0] compB;
    logic [5:0] compC;
  } pixel_s;
endpackage

// file: verilog/oled_ram_addressing_remap.sv
// Byte FIFO and command interpreter for the display pixel store window logic.
// Assumes host bytes arrive on mclk; scan indices come from a local timing engine.
`timescale 1ns/1ns
module oled_byte_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input  wire logic             mclk,
  input  wire logic             srst,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  // The pointers wrap by overflow, so only powers of two keep them in step with the count.
  if (WIDTH < 1 || DEPTH < 2 || (1 << AW) != DEPTH)
  begin
    $error("FIFO needs a width of at least one and a power-of-two depth of at least two");
  end

  typedef struct packed {
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0]   count;
    logic          ready;
  } fifo_state_s;

  logic [WIDTH-1:0] mem [DEPTH];
  fifo_state_s      cur;
  fifo_state_s      next_cur;
  logic             push;
  logic             pop;

  assign push     = inValid && cur.ready;
  assign pop      = outValid && outReady;
  assign outValid = cur.count != '0;
  assign outData  = mem[cur.rdPtr];
  assign inReady  = cur.ready;

  always_comb
  begin
    next_cur = cur;
    if (push)
      next_cur.wrPtr = cur.wrPtr + 1'b1;
    if (pop)
      next_cur.rdPtr = cur.rdPtr + 1'b1;
    next_cur.count = cur.count + (AW+1)'(push) - (AW+1)'(pop);
    // Registered ready keeps the full flag off any combinational path to the host.
    next_cur.ready = next_cur.count != (AW+1)'(DEPTH);
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      cur <= '{wrPtr: '0, rdPtr: '0, count: '0, ready: 1'b1};
    end
    else
    begin
      cur <= next_cur;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (push)
      mem[cur.wrPtr] <= inData;
  end
endmodule

module oled_ram_addressing_remap (
  input  wire logic                  mclk,
  input  wire logic                  srst,
  input  wire logic                  hostValid,
  output logic                       hostReady,
  input  wire oled_pkg::host_byte_s  hostByte,
  input  wire logic                  readRequest,
  output oled_pkg::pixel_s           readPixel,
  output logic                       readValid,
  input  wire logic [6:0]            scanPin,
  input  wire logic [6:0]            scanColumn,
  input  wire logic [6:0]            muxRatioMinus1,
  output oled_pkg::pixel_s           segmentColumnOutput,
  output logic                       commonRowOutput,
  output logic [6:0]                 shownRow,
  output oled_pkg::depth_e           colourDepth
);
  import oled_pkg::*;

  typedef struct packed {
    mode_e      mode;
    logic [7:0] cmd;
    logic [1:0] paramCount;
    logic [6:0] colStart;
    logic [6:0] colEnd;
    logic [6:0] rowStart;
    logic [6:0] rowEnd;
    logic [6:0] colPtr;
    logic [6:0] rowPtr;
    logic [7:0] remap;
    logic [6:0] startLine;
    logic [15:0] pixBytes;
    logic [1:0] byteCount;
    pixel_s     rdPixel;
    logic       rdValid;
    pixel_s     dispPixel;
    logic       dispDrive;
    logic [6:0] dispRow;
  } core_state_s;

  pixel_s       pixelStore [128*128];
  core_state_s  cur;
  core_state_s  next_cur;
  host_byte_s   fifoByte;
  logic         fifoValid;
  logic         fifoPop;
  logic         storeWrite;
  pixel_s       storeData;
  logic [6:0]   logicalCom;
  logic [6:0]   scanCom;
  logic [6:0]   ramColumn;
  pixel_s       rawPixel;
  logic [1:0]   bytesPerPixel;

  // Host reads take priority over draining, so the FIFO fills and pushes back.
  assign fifoPop = !(readRequest && cur.mode == ST_READ);

  oled_byte_fifo #(
    .WIDTH ($bits(host_byte_s)),
    .DEPTH (FIFO_DEPTH)
  ) byteFifo (
    .mclk     (mclk),
    .srst     (srst),
    .inValid  (hostValid),
    .inReady  (hostReady),
    .inData   (hostByte),
    .outValid (fifoValid),
    .outReady (fifoPop),
    .outData  (fifoByte)
  );

  function automatic logic [13:0] advance(input core_state_s s);
    logic [6:0] c;
    logic [6:0] r;
    c = s.colPtr;
    r = s.rowPtr;
    if (!s.remap[REMAP_VERTICAL])
    begin
      if (s.colPtr == s.colEnd)
      begin
        c = s.colStart;
        r = (s.rowPtr == s.rowEnd) ? s.rowStart : s.rowPtr + 7'h01;
      end
      else
        c = s.colPtr + 7'h01;
    end
    else
    begin
      if (s.rowPtr == s.rowEnd)
      begin
        r = s.rowStart;
        c = (s.colPtr == s.colEnd) ? s.colStart : s.colPtr + 7'h01;
      end
      else
        r = s.rowPtr + 7'h01;
    end
    return {c, r};
  endfunction

  always_comb
  begin
    unique case (depth_e'(cur.remap[7:REMAP_DEPTH_LO]))
      DEPTH_256:   bytesPerPixel = 2'h1;
      DEPTH_65K:   bytesPerPixel = 2'h2;
      DEPTH_262K,
      DEPTH_P262K: bytesPerPixel = 2'h3;
    endcase
  end

  always_comb
  begin
    next_cur   = cur;
    storeWrite = 1'b0;
    storeData  = '0;
    next_cur.rdValid = 1'b0;
    if (cur.mode == ST_READ && readRequest)
    begin
      next_cur.rdPixel = pixelStore[{cur.rowPtr, cur.colPtr}];
      next_cur.rdValid = 1'b1;
      {next_cur.colPtr, next_cur.rowPtr} = advance(cur);
    end
    else if (fifoValid)
    begin
      if (!fifoByte.isData)
      begin
        next_cur.cmd        = fifoByte.value;
        next_cur.paramCount = 2'h0;
        next_cur.byteCount  = 2'h0;
        unique case (fifoByte.value)
          CMD_WRITE_RAM: next_cur.mode = ST_WRITE;
          CMD_READ_RAM:  next_cur.mode = ST_READ;
          CMD_COLUMN, CMD_ROW, CMD_REMAP, CMD_START: next_cur.mode = ST_PARAM;
          default:       next_cur.mode = ST_IDLE;
        endcase
      end
      else if (cur.mode == ST_WRITE)
      begin
        next_cur.byteCount = cur.byteCount + 2'h1;
        next_cur.pixBytes  = {cur.pixBytes[7:0], fifoByte.value};
        if (cur.byteCount + 2'h1 == bytesPerPixel)
        begin
          storeWrite = 1'b1;
          next_cur.byteCount = 2'h0;
          unique case (bytesPerPixel)
            2'h1:    storeData = {10'h000, fifoByte.value};
            2'h2:    storeData = {2'h0, cur.pixBytes[7:0], fifoByte.value};
            default: storeData = {cur.pixBytes[13:8], cur.pixBytes[5:0], fifoByte.value[5:0]};
          endcase
          {next_cur.colPtr, next_cur.rowPtr} = advance(cur);
        end
      end
      else if (cur.mode == ST_PARAM)
      begin
        next_cur.paramCount = cur.paramCount + 2'h1;
        unique case (cur.cmd)
          CMD_COLUMN:
          begin
            if (cur.paramCount == 2'h0)
            begin
              next_cur.colStart = fifoByte.value[6:0];
              next_cur.colPtr   = fifoByte.value[6:0];
            end
            else
            begin
              next_cur.colEnd = fifoByte.value[6:0];
              next_cur.mode   = ST_IDLE;
            end
          end
          CMD_ROW:
          begin
            if (cur.paramCount == 2'h0)
            begin
              next_cur.rowStart = fifoByte.value[6:0];
              next_cur.rowPtr   = fifoByte.value[6:0];
            end
            else
            begin
              next_cur.rowEnd = fifoByte.value[6:0];
              next_cur.mode   = ST_IDLE;
            end
          end
          CMD_REMAP:
          begin
            next_cur.remap = fifoByte.value;
            next_cur.mode  = ST_IDLE;
          end
          default:
          begin
            next_cur.startLine = fifoByte.value[6:0];
            next_cur.mode      = ST_IDLE;
          end
        endcase
      end
    end

    // Display side: pin to logical common, direction, then RAM row and column.
    logicalCom = cur.remap[REMAP_SPLIT] ? {scanPin[5:0], scanPin[6]} : scanPin;
    scanCom    = cur.remap[REMAP_SCANREV] ? muxRatioMinus1 - logicalCom : logicalCom;
    ramColumn  = cur.remap[REMAP_MIRROR] ? ADDR_MAX - scanColumn : scanColumn;
    next_cur.dispRow   = cur.startLine + scanCom;
    next_cur.dispDrive = logicalCom <= muxRatioMinus1;
    rawPixel = pixelStore[{cur.startLine + scanCom, ramColumn}];
    next_cur.dispPixel = cur.remap[REMAP_SWAP] ?
      pixel_s'{compA: rawPixel.compC, compB: rawPixel.compB, compC: rawPixel.compA} : rawPixel;
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      cur <= '{mode: ST_IDLE, cmd: 8'h00, paramCount: 2'h0, colStart: 7'h00, colEnd: ADDR_MAX,
               rowStart: 7'h00, rowEnd: ADDR_MAX, colPtr: 7'h00, rowPtr: 7'h00, remap: REMAP_RESET,
               startLine: START_RESET, pixBytes: 16'h0000, byteCount: 2'h0, rdPixel: '0,
               rdValid: 1'b0, dispPixel: '0, dispDrive: 1'b0, dispRow: 7'h00};
    end
    else
    begin
      cur <= next_cur;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (storeWrite)
      pixelStore[{cur.rowPtr, cur.colPtr}] <= storeData;
  end

  assign readPixel           = cur.rdPixel;
  assign readValid           = cur.rdValid;
  assign segmentColumnOutput = cur.dispPixel;
  assign commonRowOutput     = cur.dispDrive;
  assign shownRow            = cur.dispRow;
  assign colourDepth         = depth_e'(cur.remap[7:REMAP_DEPTH_LO]);
endmodule

// file: test/oled_ram_addressing_remap_chk.sv
// Port-level checker for the OLED addressing block.
// Assumes it is bound into the top module and sees only its ports.
`timescale 1ns/1ns
module oled_remap_chk (
  input wire logic             mclk,
  input wire logic             srst,
  input wire logic             hostValid,
  input wire logic             hostReady,
  input wire logic             readRequest,
  input wire logic             readValid,
  input wire oled_pkg::pixel_s readPixel,
  input wire logic [6:0]       scanPin,
  input wire logic [6:0]       muxRatioMinus1,
  input wire logic             commonRowOutput,
  input wire logic [6:0]       shownRow,
  input wire oled_pkg::depth_e colourDepth
);
  import oled_pkg::*;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);
  rd_cause_a: assert property (readValid |-> $past(readRequest)) else $error("read without request");
  rd_stream_a: assert property (readValid && readRequest |=> readValid)
    else $error("read stream broken");
  rd_hold_a: assert property (!readValid |-> $stable(readPixel))
    else $error("read pixel moved");
  rst_state_a: assert property ($fell(srst) |-> colourDepth == DEPTH_65K && shownRow == 7'h00 && hostReady)
    else $error("state after reset wrong");
  com_full_a: assert property (muxRatioMinus1 == 7'h7f |=> commonRowOutput)
    else $error("common off at full ratio");
  com_first_a: assert property (scanPin == 7'h00 |=> commonRowOutput)
    else $error("first common off");
  com_last_a: assert property (scanPin == 7'h7f && muxRatioMinus1 != 7'h7f |=> !commonRowOutput)
    else $error("last common driven");
  full_cause_a: assert property ($fell(hostReady) |-> $past(hostValid) || $past(hostValid, 2))
    else $error("ready fell without bytes");
  cover property (readValid && readRequest);
  cover property (!hostReady);
  cover property (colourDepth == DEPTH_P262K);
endmodule

// file: test/oled_host_model.sv
// Host model offering command and data bytes over valid and ready.
// Assumes ready is sampled on the rising edge of mclk.
`timescale 1ns/1ns
module oled_host_model (
  input  wire logic            mclk,
  input  wire logic            hostReady,
  output logic                 hostValid,
  output oled_pkg::host_byte_s hostByte
);
  import oled_pkg::*;
  initial
  begin
    hostValid = 1'b0;
    hostByte  = '0;
  end
  // Valid stays up after the byte is taken so back-to-back sends need no gap; idle ends a burst.
  task automatic send(input logic isData, input logic [7:0] value, output logic taken);
    hostValid = 1'b1;
    hostByte  = '{isData, value};
    taken     = 1'b0;
    for (int n = 0; n < 8 && !taken; n++)
    begin
      // Ready is registered, so its settled value here is what the coming edge samples.
      taken = hostReady;
      @(posedge mclk);
      #1;
    end
  endtask
  // A released lane shows the inverse of its last value so a stale byte cannot pass.
  task automatic idle();
    hostValid = 1'b0;
    hostByte  = ~hostByte;
  endtask
endmodule

// file: test/oled_ram_addressing_remap_tb.sv
// Bench for the OLED addressing block with a host model in front.
// Assumes the package, the design and the host model are compiled first.
`timescale 1ns/1ns
module oled_ram_addressing_remap_tb;
  import oled_pkg::*;
  logic       mclk = 1'b0;
  logic       srst;
  logic       hostValid;
  logic       hostReady;
  logic       readRequest = 1'b0;
  logic       readValid;
  logic       commonRowOutput;
  logic [6:0] scanPin = 7'h00;
  logic [6:0] scanColumn = 7'h00;
  logic [6:0] muxRatioMinus1 = 7'h7f;
  logic [6:0] shownRow;
  host_byte_s hostByte;
  pixel_s     readPixel;
  pixel_s     segmentColumnOutput;
  depth_e     colourDepth;
  int         errCount = 0;
  int         checksDone = 0;

  always #2 mclk = ~mclk;

  oled_ram_addressing_remap dut (.mclk(mclk), .srst(srst), .hostValid(hostValid), .hostReady(hostReady),
    .hostByte(hostByte), .readRequest(readRequest), .readPixel(readPixel), .readValid(readValid),
    .scanPin(scanPin), .scanColumn(scanColumn), .muxRatioMinus1(muxRatioMinus1), .shownRow(shownRow),
    .segmentColumnOutput(segmentColumnOutput), .commonRowOutput(commonRowOutput), .colourDepth(colourDepth));
  oled_host_model host (.mclk(mclk), .hostReady(hostReady), .hostValid(hostValid), .hostByte(hostByte));

  task automatic testDone();
    $display("Checks %0d, mismatches %0d", checksDone, errCount);
    if (errCount == 0 && checksDone > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [17:0] got, input logic [17:0] exp, input string what);
    checksDone++;
    if (got !== exp)
    begin
      errCount++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic put(input logic isData, input logic [7:0] v);
    logic ok;
    host.send(isData, v, ok);
    if (!ok)
    begin
      errCount++;
      $display("Error at %0t: byte not taken", $time);
      testDone();
    end
  endtask
  // Commands carry no completion flag, so allow a full FIFO worth of pops.
  task automatic settle();
    host.idle();
    tick(20);
  endtask
  function automatic pixel_s px(input int k);
    return '{6'(k), 6'(k + 1), 6'(k + 2)};
  endfunction
  task automatic pix(input int k);
    put(1'b1, 8'(k));
    put(1'b1, 8'(k + 1));
    put(1'b1, 8'(k + 2));
  endtask
  task automatic remap(input logic [7:0] v);
    put(1'b0, CMD_REMAP);
    put(1'b1, v);
  endtask
  task automatic window();
    put(1'b0, CMD_COLUMN);
    put(1'b1, 8'h02);
    put(1'b1, 8'h03);
    put(1'b0, CMD_ROW);
    put(1'b1, 8'h05);
    put(1'b1, 8'h06);
  endtask
  task automatic readBurst(input pixel_s exp[$]);
    readRequest = 1'b1;
    foreach (exp[i])
    begin
      tick(1);
      if (i == exp.size() - 1)
        readRequest = 1'b0;
      check(18'(readValid), 18'h1, "read valid");
      check(readPixel, exp[i], "read pixel");
    end
  endtask
  task automatic doReset();
    srst = 1'b1;
    tick(4);
    srst = 1'b0;
    tick(1);
    check(18'(colourDepth), 18'(DEPTH_65K), "reset depth");
    check(18'(shownRow), 18'h0, "reset start line");
    $display("reset test done");
  endtask
  task automatic horizontal();
    remap(8'h80);
    window();
    put(1'b0, CMD_WRITE_RAM);
    for (int k = 0; k < 5; k++)
      pix(k * 3);
    settle();
    window();
    put(1'b0, CMD_READ_RAM);
    settle();
    readBurst('{px(12), px(3), px(6), px(9), px(12)});
    $display("horizontal test done");
  endtask
  task automatic vertical();
    remap(8'h81);
    window();
    put(1'b0, CMD_WRITE_RAM);
    for (int k = 0; k < 4; k++)
      pix(k * 3 + 20);
    remap(8'h80);
    window();
    put(1'b0, CMD_READ_RAM);
    settle();
    readBurst('{px(20), px(26), px(23), px(29)});
    $display("vertical test done");
  endtask
  task automatic depths();
    for (int d = 0; d < 4; d++)
    begin
      remap(8'(d << 6));
      settle();
      check(18'(colourDepth), 18'(d), "colour depth");
    end
    $display("depth test done");
  endtask
  task automatic look(input logic [7:0] r, input logic [6:0] pin, input logic [6:0] col, input logic [6:0] row,
                      input logic on);
    remap(r);
    settle();
    scanPin = pin;
    scanColumn = col;
    tick(2);
    if (on)
      check(18'(shownRow), 18'(row), "shown row");
    check(18'(commonRowOutput), 18'(on), "common enable");
  endtask
  task automatic scan();
    put(1'b0, CMD_START);
    put(1'b1, 8'h05);
    look(8'h80, 7'h7e, 7'h02, 7'h03, 1'b1);
    muxRatioMinus1 = 7'h63;
    look(8'h80, 7'h03, 7'h02, 7'h08, 1'b1);
    look(8'h80, 7'h64, 7'h02, 7'h00, 1'b0);
    look(8'h80, 7'h7f, 7'h02, 7'h00, 1'b0);
    look(8'h90, 7'h03, 7'h02, 7'h65, 1'b1);
    look(8'ha0, 7'h03, 7'h02, 7'h0b, 1'b1);
    look(8'ha0, 7'h41, 7'h02, 7'h08, 1'b1);
    look(8'h82, 7'h00, 7'h7d, 7'h05, 1'b1);
    check(segmentColumnOutput, px(20), "mirrored pixel");
    look(8'h84, 7'h00, 7'h02, 7'h05, 1'b1);
    check(segmentColumnOutput, {6'h16, 6'h15, 6'h14}, "swapped pixel");
    $display("scan test done");
  endtask
  // Narrow depths pack one pixel from two bytes or from one; reads outside read mode are ignored.
  task automatic packing();
    remap(8'h40);
    window();
    put(1'b0, CMD_WRITE_RAM);
    put(1'b1, 8'h12);
    put(1'b1, 8'h34);
    remap(8'h00);
    put(1'b0, CMD_WRITE_RAM);
    put(1'b1, 8'h9a);
    settle();
    readRequest = 1'b1;
    tick(2);
    readRequest = 1'b0;
    check(18'(readValid), 18'h0, "read outside read mode");
    window();
    put(1'b0, CMD_READ_RAM);
    settle();
    readBurst('{18'h01234, 18'h0009a});
    $display("packing test done");
  endtask
  // Reads held high stall the FIFO, so it fills from the host side and must refuse.
  task automatic fill();
    int   taken;
    logic ok;
    put(1'b0, CMD_READ_RAM);
    settle();
    readRequest = 1'b1;
    taken = 0;
    ok = 1'b1;
    while (ok && taken < 40)
    begin
      host.send(1'b1, 8'h55, ok);
      if (ok)
        taken++;
    end
    host.idle();
    readRequest = 1'b0;
    check(18'(taken), 18'(FIFO_DEPTH), "bytes taken");
    settle();
    check(18'(hostReady), 18'h1, "ready after drain");
    $display("fifo test done");
  endtask

  initial
  begin
    doReset();
    horizontal();
    vertical();
    depths();
    scan();
    packing();
    fill();
    doReset();
    testDone();
  end
endmodule

bind oled_ram_addressing_remap oled_remap_chk chk (.mclk(mclk), .srst(srst), .hostValid(hostValid),
  .hostReady(hostReady), .readRequest(readRequest), .readValid(readValid), .readPixel(readPixel),
  .scanPin(scanPin), .muxRatioMinus1(muxRatioMinus1), .commonRowOutput(commonRowOutput),
  .shownRow(shownRow), .colourDepth(colourDepth));
